// file: rtl/sram_host_params.svh
// Constants for the latched-address static RAM host controller
`ifndef SRAM_HOST_PARAMS_SVH
`define SRAM_HOST_PARAMS_SVH

// Clock rate
`define CLK_PERIOD_NS            100

// Device timing figures in ns
`define STROBE_HIGH_MIN_TIME_NS  100
`define STROBE_LOW_TIME_NS       250
`define ADDR_HOLD_TIME_NS        50
`define WRITE_PULSE_WIDTH_NS     130
`define WRITE_TO_OUTPUT_OFF_NS   160
`define DATA_SETUP_TIME_NS       110

// Least times round up to whole cycles
`define NS_TO_CYC_UP(t)          (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_HIGH_CYC          `NS_TO_CYC_UP(`STROBE_HIGH_MIN_TIME_NS)
`define STROBE_LOW_CYC           `NS_TO_CYC_UP(`STROBE_LOW_TIME_NS)
`define ADDR_HOLD_CYC            `NS_TO_CYC_UP(`ADDR_HOLD_TIME_NS)
`define WRITE_PULSE_CYC          `NS_TO_CYC_UP(`WRITE_PULSE_WIDTH_NS)
`define WRITE_OFF_CYC            `NS_TO_CYC_UP(`WRITE_TO_OUTPUT_OFF_NS)
`define DATA_SETUP_CYC           `NS_TO_CYC_UP(`DATA_SETUP_TIME_NS)

// Pin synchroniser depth, added to the read wait so sampled data is settled
`define SYNC_STAGES              2

// Counter width and reset values
`define CNT_W                    8
`define CNT_ZERO                 8'h00
`define LEVEL_HIGH               1'b1
`define LEVEL_LOW                1'b0

`endif

// file: rtl/sram_host_pkg.sv
// Types for the latched-address static RAM host controller
package sram_host_pkg;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_POWERUP  = 3'b000,
      ST_IDLE     = 3'b001,
      ST_STROBE   = 3'b010,
      ST_WRITE    = 3'b011,
      ST_READ     = 3'b100,
      ST_RECOVER  = 3'b101
   } host_state_type;

endpackage : sram_host_pkg

// file: rtl/sram_host_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps

module sram_host_sync #(
   parameter int WIDTH = 4
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             nrst,
   // Asynchronous level in, synchronised level out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_r;   // First stage, read only by second stage

   // ------------------------------------------------------------
   // Two flops in series
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         meta_r   <= '0;
         sync_out <= '0;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule : sram_host_sync

// file: rtl/sram_host_ctrl.sv
// Host-side controller driving a latched-address static RAM
`timescale 1ns/1ps
`include "sram_host_params.svh"

// Summary of operation
// - Address may change after hold interval
// - Strobe high, deselected between cycles
// - Write strobe falls early enough before rise
// - Write ends on first rising edge
// - Back-to-back writes time to strobe rise
// - Wait output-off delay before driving data
// - Strobe high throughout retention, except a cycle already running when retain_req rises
// - Hold a select deselected during retention; in a cycle already running both selects stay low until it ends
// - Wait strobe-high minimum after power good
module sram_host_ctrl #(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 4
) (
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              nrst,
   // User request port
   input  wire logic              req_valid,
   input  wire logic              req_write,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_wdata,
   input  wire logic              retain_req,
   input  wire logic              supply_good,
   output logic                   req_ready,
   output logic                   rsp_valid,
   output logic      [DATA_W-1:0] rsp_rdata,
   // Device pins
   output logic                   strobe_n,
   output logic                   select_one_n,
   output logic                   select_two_n,
   output logic                   write_n,
   output logic      [ADDR_W-1:0] addr,
   output logic      [DATA_W-1:0] dq_out,
   output logic                   dq_oe,
   input  wire logic [DATA_W-1:0] dq_in
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   sram_host_pkg::host_state_type state_r;    // Sequencer state
   logic [`CNT_W-1:0]             cnt_r;      // Cycles in current state
   logic                          wr_r;       // Current cycle is a write
   logic [DATA_W-1:0]             wdata_r;    // Write data held for cycle
   logic [DATA_W-1:0]             dq_sync;    // Synchronised read bus
   logic                          pwr_good;   // Synchronised supply-good level
   logic                          req_take;   // Request accepted at this edge

   // Saturating increment, used by the counter
   function automatic logic [`CNT_W-1:0] inc_sat(input logic [`CNT_W-1:0] v);
      inc_sat = (&v) ? v : v + 8'h01;
   endfunction : inc_sat

   // Compare a count against a cycle figure
   function automatic logic reached(input logic [`CNT_W-1:0] v, input int n);
      reached = (v >= n[`CNT_W-1:0]);
   endfunction : reached

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   sram_host_sync #(.WIDTH(DATA_W)) u_dq_sync (
      .sys_clk  (sys_clk),
      .nrst     (nrst),
      .async_in (dq_in),
      .sync_out (dq_sync)
   );

   sram_host_sync #(.WIDTH(1)) u_pwr_sync (
      .sys_clk  (sys_clk),
      .nrst     (nrst),
      .async_in (supply_good),
      .sync_out (pwr_good)
   );

   // Taken only on an edge where ready was shown; retention wins at that edge,
   // so a request that meets a rising retain_req stays pending and must be held
   assign req_take = (state_r == sram_host_pkg::ST_IDLE) && req_valid && req_ready &&
                     !retain_req;

   // ------------------------------------------------------------
   // Sequencer and cycle counter
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         state_r <= sram_host_pkg::ST_POWERUP;
         cnt_r   <= `CNT_ZERO;
      end else begin
         cnt_r <= inc_sat(cnt_r);
         unique case (state_r)
            // Count strobe-high time only once supply is good
            sram_host_pkg::ST_POWERUP: begin
               if (!pwr_good) begin
                  cnt_r <= `CNT_ZERO;
               end else if (reached(cnt_r, `STROBE_HIGH_CYC)) begin
                  state_r <= sram_host_pkg::ST_IDLE;
               end
            end
            // Retention holds us here with strobe high
            sram_host_pkg::ST_IDLE: begin
               if (req_take) begin
                  state_r <= sram_host_pkg::ST_STROBE;
                  cnt_r   <= `CNT_ZERO;
               end
            end
            // Strobe low, address held through hold interval
            sram_host_pkg::ST_STROBE: begin
               if (reached(cnt_r, `ADDR_HOLD_CYC - 1)) begin
                  state_r <= wr_r ? sram_host_pkg::ST_WRITE : sram_host_pkg::ST_READ;
                  cnt_r   <= `CNT_ZERO;
               end
            end
            // Write pulse long enough for width, setup and lead
            sram_host_pkg::ST_WRITE: begin
               if (reached(cnt_r, `WRITE_PULSE_CYC + `WRITE_OFF_CYC)) begin
                  state_r <= sram_host_pkg::ST_RECOVER;
                  cnt_r   <= `CNT_ZERO;
               end
            end
            // Strobe low time plus two sync stages before sampling
            sram_host_pkg::ST_READ: begin
               if (reached(cnt_r, `STROBE_LOW_CYC + `SYNC_STAGES)) begin
                  state_r <= sram_host_pkg::ST_RECOVER;
                  cnt_r   <= `CNT_ZERO;
               end
            end
            // Strobe high and deselected before the next fall
            sram_host_pkg::ST_RECOVER: begin
               if (reached(cnt_r, `STROBE_HIGH_CYC - 1)) begin
                  state_r <= sram_host_pkg::ST_IDLE;
               end
            end
            default: begin
               state_r <= sram_host_pkg::ST_POWERUP;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Request capture: address and data held for the whole cycle
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         wr_r    <= `LEVEL_LOW;
         wdata_r <= '0;
         addr    <= '0;
      end else if (req_take) begin
         wr_r    <= req_write;
         wdata_r <= req_wdata;
         addr    <= req_addr;
      end
   end

   // ------------------------------------------------------------
   // Device pin drive
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         strobe_n     <= `LEVEL_HIGH;
         select_one_n <= `LEVEL_HIGH;
         select_two_n <= `LEVEL_HIGH;
         write_n      <= `LEVEL_HIGH;
         dq_out       <= '0;
         dq_oe        <= `LEVEL_LOW;
      end else begin
         // Strobe falls one cycle after address is set up
         strobe_n <= !(state_r == sram_host_pkg::ST_STROBE ||
                       state_r == sram_host_pkg::ST_WRITE  ||
                       state_r == sram_host_pkg::ST_READ);
         // Both selects low only inside a cycle
         select_one_n <= !(state_r == sram_host_pkg::ST_WRITE ||
                           state_r == sram_host_pkg::ST_READ);
         select_two_n <= !(state_r == sram_host_pkg::ST_WRITE ||
                           state_r == sram_host_pkg::ST_READ);
         // Write strobe low through the write window; released between cycles,
         // never held across back-to-back writes, so data times to its own rise
         write_n <= !(state_r == sram_host_pkg::ST_WRITE);
         // Drive data only after output-off delay elapsed
         dq_oe  <= (state_r == sram_host_pkg::ST_WRITE) &&
                   reached(cnt_r, `WRITE_OFF_CYC);
         dq_out <= wdata_r;
      end
   end

   // ------------------------------------------------------------
   // Read response and ready
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         rsp_valid <= `LEVEL_LOW;
         rsp_rdata <= '0;
         req_ready <= `LEVEL_LOW;
      end else begin
         rsp_valid <= `LEVEL_LOW;
         // Sample at end of the read window, bus settled
         if (state_r == sram_host_pkg::ST_READ &&
             reached(cnt_r, `STROBE_LOW_CYC + `SYNC_STAGES)) begin
            rsp_valid <= `LEVEL_HIGH;
            rsp_rdata <= dq_sync;
         end
         // Ready drops on the taking edge, so one request per ready window
         req_ready <= (state_r == sram_host_pkg::ST_IDLE) && !req_take &&
                      !retain_req && pwr_good;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_strobe_high_retain: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_r == sram_host_pkg::ST_IDLE && retain_req) |=> strobe_n)
      else $error("strobe low during retention");

   chk_no_start_retain: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_r == sram_host_pkg::ST_IDLE && retain_req) |=> (state_r == sram_host_pkg::ST_IDLE))
      else $error("cycle started during retention");

   chk_sel_off_idle: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_r == sram_host_pkg::ST_IDLE) |=> select_one_n)
      else $error("select asserted outside a cycle");

   chk_write_inside_strobe: assert property (@(posedge sys_clk) disable iff (!nrst)
      !write_n |-> (!strobe_n && !select_one_n && !select_two_n))
      else $error("write strobe outside selected cycle");

   chk_data_after_off: assert property (@(posedge sys_clk) disable iff (!nrst)
      $rose(dq_oe) |-> $past(!write_n, 2))
      else $error("data driven too soon after write fall");

   chk_oe_only_write: assert property (@(posedge sys_clk) disable iff (!nrst)
      dq_oe |-> !write_n)
      else $error("data driven outside write pulse");

   chk_strobe_high_gap: assert property (@(posedge sys_clk) disable iff (!nrst)
      $rose(strobe_n) |=> strobe_n)
      else $error("strobe high interval too short");

   chk_write_width: assert property (@(posedge sys_clk) disable iff (!nrst)
      $fell(write_n) |-> !write_n [*3])
      else $error("write pulse too short");

   chk_addr_stable: assert property (@(posedge sys_clk) disable iff (!nrst)
      !strobe_n |-> $stable(addr))
      else $error("address moved during strobe low");

   chk_powerup_wait: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_r == sram_host_pkg::ST_POWERUP) |=> strobe_n)
      else $error("cycle started before power-up wait");

endmodule : sram_host_ctrl

// file: dv/sram_dev_model.sv
// Behavioural model of the latched-address static RAM at the far side
`timescale 1ns/1ps

module sram_dev_model (
   // Control pins from the host
   input  wire logic       strobe_n,
   input  wire logic       select_one_n,
   input  wire logic       select_two_n,
   input  wire logic       write_n,
   // Address and data pins
   input  wire logic [7:0] addr,
   input  wire logic [3:0] dq_out,
   input  wire logic       dq_oe,
   output logic      [3:0] dq_in
);
   logic [3:0] mem_r [0:255];  // Storage array
   logic [7:0] addr_r;         // Latched address
   logic [3:0] q_r;            // Output register
   logic       sel;            // Both selects low
   logic       drv;            // Output buffers on

   // -------------------------------------------------
   // Select and output buffer enables
   // -------------------------------------------------
   assign sel = !select_one_n && !select_two_n;
   assign drv = sel && write_n;

   // Address latches on strobe fall; later changes ignored
   always @(negedge strobe_n) begin
      addr_r = addr;
   end

   // Store while all four are low and dq_oe is high; last value present wins
   always @* begin
      if (!strobe_n && !write_n && sel && dq_oe) begin
         mem_r[addr_r] = dq_out;
      end
   end

   // Register follows while strobe low, holds after the rise
   always @* begin
      if (!strobe_n) begin
         q_r = mem_r[addr_r];
      end
   end

   // Floating bus shows the inverse, so a stale value never passes
   assign dq_in = dq_oe ? dq_out : (drv ? q_r : ~q_r);
endmodule : sram_dev_model

// file: dv/tb_top.sv
// Self-checking testbench for the static RAM host controller
`timescale 1ns/1ps
`include "sram_host_params.svh"

module tb_top;
   logic       sys_clk, nrst, req_valid, req_write, retain_req, supply_good;
   logic [7:0] req_addr;
   logic [3:0] req_wdata, rsp_rdata, dq_out, dq_in;
   logic       req_ready, rsp_valid, strobe_n, select_one_n, select_two_n;
   logic       write_n, dq_oe;
   logic [7:0] addr;
   int         errors, tests_run;

   // -------------------------------------------------
   // Design and device model
   // -------------------------------------------------
   sram_host_ctrl u_dut (.sys_clk(sys_clk), .nrst(nrst), .req_valid(req_valid),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .retain_req(retain_req), .supply_good(supply_good), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .strobe_n(strobe_n),
      .select_one_n(select_one_n), .select_two_n(select_two_n), .write_n(write_n),
      .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
   sram_dev_model u_mem (.strobe_n(strobe_n), .select_one_n(select_one_n),
      .select_two_n(select_two_n), .write_n(write_n), .addr(addr),
      .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));

   // Clock at 100 ns period
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   // Compare and count
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // Verdict and end of run
   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : finish_test

   // Offer one request and wait until it is taken
   task automatic issue(input logic w, input logic [7:0] a, input logic [3:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr  <= a;
      req_wdata <= d;
      do begin
         @(negedge sys_clk);
         n++;
      end while (req_ready !== 1'b1 && n < 100);
      check("ready", 8'h01, {7'h00, req_ready});
      @(posedge sys_clk);
      req_valid <= 1'b0;
   endtask : issue

   // Read one word and compare with the expected value
   task automatic read_cmp(input logic [7:0] a, input logic [3:0] exp);
      int n;
      n = 0;
      issue(1'b0, a, 4'h0);
      while (rsp_valid !== 1'b1 && n < 40) begin
         @(negedge sys_clk);
         n++;
      end
      check("rsp_valid", 8'h01, {7'h00, rsp_valid});
      check("rdata", {4'h0, exp}, {4'h0, rsp_rdata});
   endtask : read_cmp

   // Supply low holds off every cycle
   task automatic test_power_up;
      repeat (10) @(negedge sys_clk);
      check("ready_nosupply", 8'h00, {7'h00, req_ready});
      check("strobe_nosupply", 8'h01, {7'h00, strobe_n});
      @(posedge sys_clk);
      supply_good <= 1'b1;
   endtask : test_power_up

   // Boundary addresses written then read back
   task automatic test_write_read;
      issue(1'b1, 8'h00, 4'hA);
      issue(1'b1, 8'hFF, 4'h5);
      issue(1'b1, 8'h3C, 4'hF);
      read_cmp(8'h00, 4'hA);
      read_cmp(8'hFF, 4'h5);
      read_cmp(8'h3C, 4'hF);
   endtask : test_write_read

   // Overwrite keeps only the newest word
   task automatic test_overwrite;
      issue(1'b1, 8'h81, 4'h1);
      issue(1'b1, 8'h81, 4'hE);
      read_cmp(8'h81, 4'hE);
      read_cmp(8'h00, 4'hA);
   endtask : test_overwrite

   // Retention blocks cycles and keeps strobe high, device deselected
   task automatic test_retention;
      @(posedge sys_clk);
      retain_req <= 1'b1;
      repeat (3) @(negedge sys_clk);
      repeat (20) begin
         @(negedge sys_clk);
         check("strobe_ret", 8'h01, {7'h00, strobe_n});
         check("sel_ret", 8'h01, {7'h00, select_one_n | select_two_n});
         check("ready_ret", 8'h00, {7'h00, req_ready});
      end
      @(posedge sys_clk);
      retain_req <= 1'b0;
      read_cmp(8'hFF, 4'h5);
   endtask : test_retention

   // -------------------------------------------------
   // Pin monitors: strobe high time, bus turn-round
   // -------------------------------------------------
   int hi_cnt, wl_cnt;
   always @(negedge sys_clk) begin
      hi_cnt = (strobe_n === 1'b1) ? hi_cnt + 1 : 0;
      wl_cnt = (write_n === 1'b0) ? wl_cnt + 1 : 0;
   end
   always @(negedge strobe_n) begin
      if (nrst === 1'b1) check("strobe_high", 8'h01, {7'h00, hi_cnt >= `STROBE_HIGH_CYC});
   end
   always @(posedge dq_oe) begin
      check("turnround", 8'h01, {7'h00, wl_cnt >= `WRITE_OFF_CYC});
   end

   // Watchdog
   initial begin
      #2000000;
      errors++;
      finish_test();
   end

   // Main sequence
   initial begin
      errors = 0;
      tests_run = 0;
      hi_cnt = 0;
      wl_cnt = 0;
      nrst = 1'b0;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 8'h00;
      req_wdata = 4'h0;
      retain_req = 1'b0;
      supply_good = 1'b0;
      repeat (12) @(posedge sys_clk);
      nrst <= 1'b1;
      test_power_up();
      test_write_read();
      test_overwrite();
      test_retention();
      finish_test();
   end
endmodule : tb_top
